/* logic/pdtok_fifo_token_irq.sv */
// event flags, token FIFO port and transmit token sequencer
`timescale 1ns/1ns
module pdtok_fifo_token_irq #(
    parameter int TX_DEPTH = pdtok_pkg::TX_FIFO_DEPTH,
    parameter int SYM_CYCLES = pdtok_pkg::SYM_LINK_CYCLES
) (
    input wire logic core_clk, // core clock, 25 MHz
    input wire logic rst_b, // synchronous reset, active low
    input wire logic link_clk, // line symbol clock
    input wire logic [7:0] reg_addr, // register address
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    input wire logic [7:0] reg_wdata, // register write data
    output logic [7:0] reg_rdata, // read data, valid cycle after strobe
    input wire logic tx_start, // transmit-start control bit pulse
    input wire pdtok_pkg::pdtok_status_type status_pins, // asynchronous status levels
    input wire logic [7:0] rx_fifo_data, // receive FIFO head byte
    input wire logic rx_fifo_full, // receive FIFO full, core domain
    output logic rx_pop, // receive FIFO pop pulse
    output pdtok_pkg::pdtok_symbol_type line_sym, // symbol to line coder
    output logic line_sym_stb, // one link cycle per symbol
    output logic line_drv_en // line transmit driver enable
);
    localparam int CW = $clog2(TX_DEPTH + 1);
    localparam int PW = $clog2(TX_DEPTH);
    localparam int LCW = $clog2(SYM_CYCLES + 1);
    localparam logic [CW-1:0] FIFO_FULL_CNT = CW'(TX_DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(TX_DEPTH - 1);
    localparam logic [LCW-1:0] LINK_CNT_LOAD = LCW'(SYM_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // status input synchronisers and change detection
    pdtok_pkg::pdtok_status_type st_s1_r, st_s2_r, st_d_r;
    logic tx_full_d_r, rx_full_d_r;
    logic [7:0] flags_r, flags_nxt, events, flag_clr;

    always_ff @(posedge core_clk) begin
        st_s1_r <= status_pins;
        st_s2_r <= st_s1_r;
        st_d_r <= st_s2_r;
    end

    wire rd_flags = reg_rd && (reg_addr == pdtok_pkg::EVENT_FLAGS_ADDR);
    wire rd_port = reg_rd && (reg_addr == pdtok_pkg::TOKEN_FIFO_ADDR);
    wire wr_port = reg_wr && (reg_addr == pdtok_pkg::TOKEN_FIFO_ADDR);
    wire go_write = wr_port && ((reg_wdata & pdtok_pkg::TRANSMIT_GO_MASK) == pdtok_pkg::TRANSMIT_GO_MATCH);
    wire push_req = wr_port && !go_write;

    logic [CW-1:0] cnt_r;
    wire tx_full = (cnt_r == FIFO_FULL_CNT);
    wire tx_empty = (cnt_r == '0);
    logic collide;

    always_comb begin
        events = '0;
        events[pdtok_pkg::SUPPLY_CROSS_BIT] = st_s2_r.supply_ok != st_d_r.supply_ok;
        events[pdtok_pkg::ACTIVITY_CHANGE_BIT] = st_s2_r.line_activity != st_d_r.line_activity;
        events[pdtok_pkg::THRESHOLD_CHANGE_BIT] = st_s2_r.comp_result != st_d_r.comp_result;
        events[pdtok_pkg::PACKET_CHECKED_BIT] = st_s2_r.packet_crc_good && !st_d_r.packet_crc_good;
        events[pdtok_pkg::ALERT_BIT] = (tx_full && !tx_full_d_r) || (rx_fifo_full && !rx_full_d_r);
        events[pdtok_pkg::WAKE_BIT] = st_s2_r.wake_detect && !st_d_r.wake_detect;
        events[pdtok_pkg::COLLISION_BIT] = collide;
        events[pdtok_pkg::CURRENT_LEVEL_CHANGE_BIT] = st_s2_r.host_current_level != st_d_r.host_current_level;
    end

    assign flag_clr = rd_flags ? flags_r : '0;
    assign flags_nxt = (flags_r & ~flag_clr) | events;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flags_r <= pdtok_pkg::EVENT_FLAGS_RESET;
            tx_full_d_r <= 1'b0;
            rx_full_d_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            tx_full_d_r <= tx_full;
            rx_full_d_r <= rx_fifo_full;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port
    wire [7:0] rdata_nxt = rd_flags ? flags_r : (rd_port ? rx_fifo_data : pdtok_pkg::RDATA_ZERO);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= pdtok_pkg::RDATA_ZERO;
            rx_pop <= 1'b0;
        end else begin
            reg_rdata <= rdata_nxt;
            rx_pop <= rd_port;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit FIFO in flip-flops
    logic [7:0] mem_r [TX_DEPTH];
    logic [PW-1:0] wr_ptr_r, rd_ptr_r;
    logic pop;
    // a write into a full FIFO is dropped; the alert flag tells software
    wire push = push_req && !tx_full;
    wire [7:0] head = mem_r[rd_ptr_r];
    wire [PW-1:0] wr_ptr_inc = (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
    wire [PW-1:0] rd_ptr_inc = (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_ptr_r <= push ? wr_ptr_inc : wr_ptr_r;
            rd_ptr_r <= pop ? rd_ptr_inc : rd_ptr_r;
            cnt_r <= cnt_r + CW'(push) - CW'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // token sequencer
    pdtok_pkg::pdtok_seq_state_type state_r, state_nxt;
    pdtok_pkg::pdtok_symbol_type sym_hold_r, sym_nxt;
    logic [4:0] data_left_r, data_left_nxt;
    logic [3:0] hi_nib_r, hi_nib_nxt;
    logic hi_pend_r, hi_pend_nxt;
    logic start_pend_r;
    logic req_r, req_nxt;
    logic ack_s1_r, ack_s2_r;
    // link-domain ack toggle, read here only through the two-stage synchroniser
    logic ack_l_r;
    logic issue;
    wire ack_done = (ack_s2_r == req_r);
    wire [2:0] head_prefix = head[7:5];

    // go write or start bit arms sequencer
    wire start_now = start_pend_r || go_write || tx_start;
    wire idle = (state_r == pdtok_pkg::PDTOK_SEQ_IDLE);
    assign collide = idle && start_now && st_s2_r.line_activity;

    always_comb begin
        state_nxt = state_r;
        sym_nxt = sym_hold_r;
        data_left_nxt = data_left_r;
        hi_nib_nxt = hi_nib_r;
        hi_pend_nxt = hi_pend_r;
        pop = 1'b0;
        issue = 1'b0;
        case (state_r)
            pdtok_pkg::PDTOK_SEQ_IDLE: begin
                if (start_now && !st_s2_r.line_activity) begin
                    state_nxt = pdtok_pkg::PDTOK_SEQ_FETCH;
                end
            end
            pdtok_pkg::PDTOK_SEQ_FETCH: begin
                if (tx_empty) begin
                    state_nxt = pdtok_pkg::PDTOK_SEQ_IDLE;
                    data_left_nxt = pdtok_pkg::DATA_LEFT_ZERO;
                end else begin
                    pop = 1'b1;
                    issue = 1'b1;
                    sym_nxt.nibble = '0;
                    if (data_left_r != pdtok_pkg::DATA_LEFT_ZERO) begin
                        sym_nxt.kind = pdtok_pkg::PDTOK_SYM_DATA;
                        sym_nxt.nibble = head[3:0];
                        hi_nib_nxt = head[7:4];
                        hi_pend_nxt = 1'b1;
                        data_left_nxt = data_left_r - pdtok_pkg::DATA_LEFT_ONE;
                    end else if (head_prefix == pdtok_pkg::PACKED_DATA_PREFIX) begin
                        data_left_nxt = head[4:0];
                        issue = 1'b0;
                    end else if (head == pdtok_pkg::SYNC_ONE_TOKEN) begin
                        sym_nxt.kind = pdtok_pkg::PDTOK_SYM_SYNC1;
                    end else if (head == pdtok_pkg::SYNC_TWO_TOKEN) begin
                        sym_nxt.kind = pdtok_pkg::PDTOK_SYM_SYNC2;
                    end else if (head == pdtok_pkg::SYNC_THREE_TOKEN) begin
                        sym_nxt.kind = pdtok_pkg::PDTOK_SYM_SYNC3;
                    end else if (head == pdtok_pkg::RST_ONE_TOKEN) begin
                        sym_nxt.kind = pdtok_pkg::PDTOK_SYM_RST1;
                    end else if (head == pdtok_pkg::RST_TWO_TOKEN) begin
                        sym_nxt.kind = pdtok_pkg::PDTOK_SYM_RST2;
                    end else if (head == pdtok_pkg::CRC_INSERT_TOKEN) begin
                        sym_nxt.kind = pdtok_pkg::PDTOK_SYM_CRC;
                    end else if (head == pdtok_pkg::PACKET_END_TOKEN) begin
                        sym_nxt.kind = pdtok_pkg::PDTOK_SYM_EOP;
                    end else if (head == pdtok_pkg::DRIVER_OFF_TOKEN) begin
                        sym_nxt.kind = pdtok_pkg::PDTOK_SYM_DRV_OFF;
                    end else begin
                        // unknown codes are consumed silently
                        issue = 1'b0;
                    end
                    if (issue) begin
                        state_nxt = pdtok_pkg::PDTOK_SEQ_WAIT;
                    end
                end
            end
            pdtok_pkg::PDTOK_SEQ_WAIT: begin
                if (ack_done) begin
                    if (hi_pend_r) begin
                        sym_nxt.kind = pdtok_pkg::PDTOK_SYM_DATA;
                        sym_nxt.nibble = hi_nib_r;
                        hi_pend_nxt = 1'b0;
                        issue = 1'b1;
                    end else begin
                        state_nxt = pdtok_pkg::PDTOK_SEQ_FETCH;
                    end
                end
            end
            default: begin
                state_nxt = pdtok_pkg::PDTOK_SEQ_IDLE;
            end
        endcase
    end

    assign req_nxt = issue ? !req_r : req_r;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= pdtok_pkg::PDTOK_SEQ_IDLE;
            sym_hold_r <= '{kind: pdtok_pkg::PDTOK_SYM_NONE, nibble: '0};
            data_left_r <= pdtok_pkg::DATA_LEFT_ZERO;
            hi_nib_r <= '0;
            hi_pend_r <= 1'b0;
            start_pend_r <= 1'b0;
            req_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sym_hold_r <= sym_nxt;
            data_left_r <= data_left_nxt;
            hi_nib_r <= hi_nib_nxt;
            hi_pend_r <= hi_pend_nxt;
            // a start while running is held until the sequencer is idle
            start_pend_r <= start_now && !idle;
            req_r <= req_nxt;
            ack_s1_r <= ack_l_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain: symbol emission, toggle handshake back to core
    logic lrst_s1_r, lrst_s2_r, req_s1_r, req_s2_r;
    logic [LCW-1:0] lcnt_r;
    wire lbusy = (lcnt_r != '0);
    // sym_hold_r is stable from the req toggle until ack returns
    wire ltake = (req_s2_r != ack_l_r) && !lbusy;

    always_ff @(posedge link_clk) begin
        lrst_s1_r <= rst_b;
        lrst_s2_r <= lrst_s1_r;
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_s2_r) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            ack_l_r <= 1'b0;
            lcnt_r <= '0;
            line_sym <= '{kind: pdtok_pkg::PDTOK_SYM_NONE, nibble: '0};
            line_sym_stb <= 1'b0;
            line_drv_en <= 1'b0;
        end else begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            line_sym_stb <= ltake;
            if (ltake) begin
                line_sym <= sym_hold_r;
                line_drv_en <= (sym_hold_r.kind != pdtok_pkg::PDTOK_SYM_DRV_OFF);
                lcnt_r <= LINK_CNT_LOAD;
            end else if (lbusy) begin
                lcnt_r <= lcnt_r - 1'b1;
            end
            if (lcnt_r == LCW'(1)) begin
                ack_l_r <= !ack_l_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_SUPPLY_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
        $changed(st_s2_r.supply_ok) |=> flags_r[pdtok_pkg::SUPPLY_CROSS_BIT])
        else $error("supply crossing did not set flag");
    AST_ACTIVITY_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
        $changed(st_s2_r.line_activity) |=> flags_r[pdtok_pkg::ACTIVITY_CHANGE_BIT])
        else $error("activity change did not set flag");
    AST_COMP_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
        $changed(st_s2_r.comp_result) |=> flags_r[pdtok_pkg::THRESHOLD_CHANGE_BIT])
        else $error("comparator change did not set flag");
    AST_CRC_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(st_s2_r.packet_crc_good) |=> flags_r[pdtok_pkg::PACKET_CHECKED_BIT])
        else $error("crc valid did not set flag");
    AST_ALERT_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(tx_full) |=> flags_r[pdtok_pkg::ALERT_BIT])
        else $error("fifo full did not raise alert");
    AST_WAKE_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(st_s2_r.wake_detect) |=> flags_r[pdtok_pkg::WAKE_BIT])
        else $error("wake did not set flag");
    AST_COLLISION: assert property (@(posedge core_clk) disable iff (!rst_b)
        idle && (go_write || tx_start) && st_s2_r.line_activity |=> flags_r[pdtok_pkg::COLLISION_BIT] && idle)
        else $error("collision not flagged or transmit started");
    AST_LEVEL_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
        $changed(st_s2_r.host_current_level) |=> flags_r[pdtok_pkg::CURRENT_LEVEL_CHANGE_BIT])
        else $error("current level change did not set flag");
    AST_PUSH_COUNT: assert property (@(posedge core_clk) disable iff (!rst_b)
        push_req && !tx_full && !pop |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("write did not push transmit fifo");
    AST_GO_NOT_STORED: assert property (@(posedge core_clk) disable iff (!rst_b)
        go_write && !pop |=> cnt_r == $past(cnt_r))
        else $error("go byte stored in fifo");
    AST_ONE_TOKEN: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_r == pdtok_pkg::PDTOK_SEQ_WAIT |-> !pop)
        else $error("fetch while a token is still running");
    AST_SYNC_ONE: assert property (@(posedge core_clk) disable iff (!rst_b)
        pop && data_left_r == '0 && head == pdtok_pkg::SYNC_ONE_TOKEN
        |=> sym_hold_r.kind == pdtok_pkg::PDTOK_SYM_SYNC1 && req_r != $past(req_r))
        else $error("sync one token did not issue symbol");
    AST_FLAG_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        flags_r[pdtok_pkg::WAKE_BIT] && !rd_flags |=> flags_r[pdtok_pkg::WAKE_BIT])
        else $error("flag dropped without read");
endmodule // pdtok_fifo_token_irq

/* logic/pdtok_pkg.sv */
// shared constants and types for the event-flag and token-port block
package pdtok_pkg;
    localparam logic [7:0] EVENT_FLAGS_ADDR = 8'h42;
    localparam logic [7:0] TOKEN_FIFO_ADDR = 8'h43;
    localparam logic [7:0] EVENT_FLAGS_RESET = 8'h00;
    localparam logic [7:0] RDATA_ZERO = 8'h00;
    // event flag bit positions
    localparam int SUPPLY_CROSS_BIT = 7;
    localparam int ACTIVITY_CHANGE_BIT = 6;
    localparam int THRESHOLD_CHANGE_BIT = 5;
    localparam int PACKET_CHECKED_BIT = 4;
    localparam int ALERT_BIT = 3;
    localparam int WAKE_BIT = 2;
    localparam int COLLISION_BIT = 1;
    localparam int CURRENT_LEVEL_CHANGE_BIT = 0;
    // transmit-go pattern 101x-xxx1
    localparam logic [7:0] TRANSMIT_GO_MASK = 8'hE1;
    localparam logic [7:0] TRANSMIT_GO_MATCH = 8'hA1;
    // token codes
    localparam logic [7:0] SYNC_ONE_TOKEN = 8'h12;
    localparam logic [7:0] SYNC_TWO_TOKEN = 8'h13;
    localparam logic [7:0] SYNC_THREE_TOKEN = 8'h1B;
    localparam logic [7:0] RST_ONE_TOKEN = 8'h15;
    localparam logic [7:0] RST_TWO_TOKEN = 8'h16;
    localparam logic [7:0] CRC_INSERT_TOKEN = 8'hFF;
    localparam logic [7:0] PACKET_END_TOKEN = 8'h14;
    localparam logic [7:0] DRIVER_OFF_TOKEN = 8'hFE;
    localparam logic [2:0] PACKED_DATA_PREFIX = 3'h4;
    localparam logic [4:0] DATA_LEFT_ZERO = 5'h00;
    localparam logic [4:0] DATA_LEFT_ONE = 5'h01;
    // line cycles per symbol on the link side
    localparam int SYM_LINK_CYCLES = 5;
    localparam int TX_FIFO_DEPTH = 48;

    typedef enum logic [3:0] {
        PDTOK_SYM_SYNC1 = 4'h1,
        PDTOK_SYM_SYNC2 = 4'h2,
        PDTOK_SYM_SYNC3 = 4'h3,
        PDTOK_SYM_RST1 = 4'h4,
        PDTOK_SYM_RST2 = 4'h5,
        PDTOK_SYM_DATA = 4'h6,
        PDTOK_SYM_CRC = 4'h7,
        PDTOK_SYM_EOP = 4'h8,
        PDTOK_SYM_DRV_OFF = 4'h9,
        PDTOK_SYM_NONE = 4'h0
    } pdtok_sym_kind_type;

    typedef struct packed {
        pdtok_sym_kind_type kind;
        logic [3:0] nibble;
    } pdtok_symbol_type;

    typedef struct packed {
        logic supply_ok;
        logic line_activity;
        logic comp_result;
        logic packet_crc_good;
        logic wake_detect;
        logic [1:0] host_current_level;
    } pdtok_status_type;

    typedef enum logic [2:0] {
        PDTOK_SEQ_IDLE = 3'b001,
        PDTOK_SEQ_FETCH = 3'b010,
        PDTOK_SEQ_WAIT = 3'b100
    } pdtok_seq_state_type;
endpackage

/* dv/pdtok_rx_partner.sv */
// receive FIFO model standing behind the token port
`timescale 1ns/1ns
module pdtok_rx_partner (
    input wire logic core_clk, // core clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic rx_pop, // pop pulse from the block
    input wire logic fill, // bench asks the FIFO to report full
    output logic [7:0] rx_fifo_data, // head byte
    output logic rx_fifo_full // full level
);
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_fifo_data <= 8'h3C;
        end else if (rx_pop) begin
            rx_fifo_data <= rx_fifo_data + 8'h11;
        end
    end
    assign rx_fifo_full = fill;
endmodule // pdtok_rx_partner

/* dv/pdtok_fifo_token_irq_bench.sv */
// self-checking bench for the event-flag and token-port block
`timescale 1ns/1ns
module pdtok_fifo_token_irq_bench;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic tx_start = 1'b0;
    logic fill = 1'b0;
    pdtok_pkg::pdtok_status_type status_pins = '0;
    logic [7:0] reg_rdata;
    logic [7:0] rx_fifo_data;
    logic rx_fifo_full;
    logic rx_pop;
    pdtok_pkg::pdtok_symbol_type line_sym;
    logic line_sym_stb;
    logic line_drv_en;
    logic rd_seen = 1'b0;
    logic [8:0] rd_q[$];
    logic [8:0] sym_q[$];
    int bad_count = 0;
    int n_checks = 0;
    int seed = 45;
    logic [7:0] rx_head = 8'h3C;
    logic [7:0] b;
    int fmap[7] = '{0, 0, 2, 4, 5, 6, 7};
    logic [7:0] toks[5] = '{8'h12, 8'h13, 8'h1B, 8'h15, 8'h16};

    always #20 core_clk = ~core_clk;
    // odd link edges never meet the even core edges
    initial #3 forever #6 link_clk = ~link_clk;

    pdtok_fifo_token_irq #(.TX_DEPTH(12), .SYM_CYCLES(2)) i_pdtok_fifo_token_irq (.core_clk(core_clk),
        .rst_b(rst_b), .link_clk(link_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_start(tx_start), .status_pins(status_pins),
        .rx_fifo_data(rx_fifo_data), .rx_fifo_full(rx_fifo_full), .rx_pop(rx_pop), .line_sym(line_sym),
        .line_sym_stb(line_sym_stb), .line_drv_en(line_drv_en));
    pdtok_rx_partner i_pdtok_rx_partner (.core_clk(core_clk), .rst_b(rst_b), .rx_pop(rx_pop), .fill(fill),
        .rx_fifo_data(rx_fifo_data), .rx_fifo_full(rx_fifo_full));

    ////////////////////////////////////////
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        rd_q.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic pulse_start;
        @(negedge core_clk);
        tx_start = 1'b1;
        @(negedge core_clk);
        tx_start = 1'b0;
    endtask

    // bounded wait for every noted symbol, then let the last ack settle
    task automatic drain;
        for (int k = 0; k < 3000 && sym_q.size() > 0; k++) @(negedge core_clk);
        if (sym_q.size() > 0) begin
            check(9'(sym_q.size()), 9'h000);
            complete_run;
        end
        wt(40);
    endtask

    ////////////////////////////////////////
    always @(posedge core_clk) rd_seen <= reg_rd;
    always @(negedge core_clk) if (rd_seen) check({rx_pop, reg_rdata}, rd_q.pop_front());
    always @(negedge link_clk) begin
        if (line_sym_stb === 1'b1) begin
            if (sym_q.size() == 0) check({1'b1, line_sym}, 9'h000);
            else if (sym_q[0][8]) check({1'b1, line_sym}, sym_q.pop_front());
            else check({1'b0, line_sym.kind, 4'h0}, sym_q.pop_front());
        end
    end

    ////////////////////////////////////////
    initial begin
        wt(8);
        rst_b = 1'b1;
        wt(4);
        rd(8'h42, 9'h000);
        rd(8'h40, 9'h000);
        $display("test reset done");
        for (int j = 0; j < 7; j++) begin
            status_pins[j] = 1'b1;
            wt(6);
            rd(8'h42, 9'(1 << fmap[j]));
            rd(8'h42, 9'h000);
            status_pins[j] = 1'b0;
            wt(6);
            rd(8'h42, (j == 2 || j == 3) ? 9'h000 : 9'(1 << fmap[j]));
        end
        fill = 1'b1;
        wt(6);
        rd(8'h42, 9'h008);
        fill = 1'b0;
        for (int k = 0; k < 3; k++) begin
            rd(8'h43, {1'b1, rx_head});
            rx_head = rx_head + 8'h11;
        end
        $display("test flags done");
        status_pins.line_activity = 1'b1;
        wt(6);
        rd(8'h42, 9'h040);
        pulse_start;
        wt(6);
        rd(8'h42, 9'h002);
        status_pins.line_activity = 1'b0;
        wt(6);
        rd(8'h42, 9'h040);
        $display("test collision done");
        for (int k = 0; k < 5; k++) begin
            acc(1'b1, 8'h43, toks[k]);
            sym_q.push_back({1'b0, 4'(k + 1), 4'h0});
        end
        acc(1'b1, 8'h43, 8'h82);
        for (int k = 0; k < 2; k++) begin
            b = {1'b0, 7'($random(seed))};
            acc(1'b1, 8'h43, b);
            sym_q.push_back({1'b1, 4'h6, b[3:0]});
            sym_q.push_back({1'b1, 4'h6, b[7:4]});
        end
        acc(1'b1, 8'h43, 8'hFF);
        acc(1'b1, 8'h43, 8'h14);
        acc(1'b1, 8'h43, 8'hFE);
        sym_q.push_back({1'b0, 4'h7, 4'h0});
        sym_q.push_back({1'b0, 4'h8, 4'h0});
        sym_q.push_back({1'b0, 4'h9, 4'h0});
        acc(1'b1, 8'h43, 8'hA1);
        drain;
        check({8'h00, line_drv_en}, 9'h000);
        $display("test transmit done");
        // thirteenth write meets a full FIFO and is dropped
        for (int k = 0; k < 13; k++) begin
            acc(1'b1, 8'h43, 8'h12);
            if (k < 12) sym_q.push_back({1'b0, 4'h1, 4'h0});
        end
        wt(6);
        rd(8'h42, 9'h008);
        pulse_start;
        drain;
        check({8'h00, line_drv_en}, 9'h001);
        $display("test fill done");
        complete_run;
    end
endmodule // pdtok_fifo_token_irq_bench
